// ===== dv/dtr_monitor.sv
module dtr_monitor import dtr_pkg::*; (
  input wire logic     mclk,
  input wire logic     rst,
  input wire dtr_cmd_t cmd,
  input wire logic     cmd_valid,
  input wire logic     auto_pre,
  input wire logic     bc4_otf,
  input wire logic     cke,
  input wire logic     dll_locked,
  input wire logic     rd_window,
  input wire logic     wr_recov_start,
  input wire logic     int_precharge
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic       ap_wr_r;
  logic [8:0] gap_r;
  wire        is_ref = cmd_valid && cmd == DTR_CMD_REF;
  wire        is_wr  = cmd_valid && cmd == DTR_CMD_WR;
  wire        is_rd  = cmd_valid && cmd == DTR_CMD_RD;
  wire        is_pd  = cmd_valid && (cmd == DTR_CMD_PDE || cmd == DTR_CMD_SRE);
  // ****
  // Helper state
  // ****
  always_ff @(posedge mclk) begin
    if (rst) begin
      ap_wr_r <= 1'b0;
    end else if (is_wr) begin
      ap_wr_r <= auto_pre;
    end else if (wr_recov_start) begin
      ap_wr_r <= 1'b0;
    end
  end
  // Saturates so a stuck refresh keeps failing instead of wrapping
  always_ff @(posedge mclk) begin
    if (rst || is_ref) begin
      gap_r <= 9'h000;
    end else if (gap_r != 9'h1ff) begin
      gap_r <= gap_r + 9'h001;
    end
  end
  // ****
  // Properties
  // ****
  sequence s_tail4; ##9 wr_recov_start; endsequence
  sequence s_tail2; ##7 wr_recov_start; endsequence
  property p_rd_lock; is_rd |-> dll_locked; endproperty
  // Delay assumes the default latencies CL 6, AL 0
  property p_rd_win; is_rd |-> ##6 rd_window; endproperty
  property p_wr_start; is_wr |-> s_tail4 or s_tail2; endproperty
  property p_act_ras; cmd_valid && cmd == DTR_CMD_ACT |=> !int_precharge; endproperty
  property p_wr_ap; wr_recov_start && ap_wr_r |-> ##4 int_precharge; endproperty
  property p_ref_gap; is_ref |=> !is_ref; endproperty
  property p_ref_pdn; is_ref |=> (cke && !is_pd)[*8]; endproperty
  property p_ref_int; gap_r <= 9'h0d2; endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("read without dll lock");
  a_rd_win: assert property (p_rd_win) else $error("read window late or missing");
  a_wr_start: assert property (p_wr_start) else $error("write recovery start off");
  a_act_ras: assert property (p_act_ras) else $error("precharge before row time");
  a_wr_ap: assert property (p_wr_ap) else $error("auto precharge not after recovery");
  a_ref_gap: assert property (p_ref_gap) else $error("refresh back to back");
  a_ref_pdn: assert property (p_ref_pdn) else $error("power down too soon after refresh");
  a_ref_int: assert property (p_ref_int) else $error("refresh interval exceeded");
endmodule

// ===== dv/tb_top.sv
`include "dtr_defines.svh"

module tb_top import dtr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic     mclk, rst, dll_disable, bc4_fixed, temp_hot, temp_xhot, slow_clk;
  logic     req_valid, req_ap, req_bc4, req_ready, refresh_busy, in_sr;
  dtr_cmd_t req_cmd;
  int       miscompares = 0;
  int       checked = 0;
  int       cyc, n_ref, t_wr, t_rd, t_ip, t_refp;
  int       t_cmd[8] = '{default: 0};
  int       r_exp[3] = '{`DTR_TREFI_CK, `DTR_TREFI_85_CK, `DTR_TREFI_105_CK};
  dtr_if lnk ();
  dtr_dev u_dtr_dev (.mclk(mclk), .rst(rst), .lnk(lnk.dev), .dll_disable(dll_disable), .bc4_fixed(bc4_fixed),
    .cl(`DTR_CL_DEF), .al(`DTR_AL_DEF), .wl(`DTR_WL_DEF), .in_self_refresh(in_sr));
  dtr_ctl u_dtr_ctl (.mclk(mclk), .rst(rst), .lnk(lnk.ctl), .temp_hot(temp_hot), .temp_xhot(temp_xhot),
    .slow_clk(slow_clk), .req_valid(req_valid), .req_cmd(req_cmd), .req_ap(req_ap), .req_bc4(req_bc4),
    .req_ready(req_ready), .refresh_busy(refresh_busy));
  dtr_monitor u_dtr_monitor (.mclk(mclk), .rst(rst), .cmd(lnk.cmd), .cmd_valid(lnk.cmd_valid),
    .auto_pre(lnk.auto_pre), .bc4_otf(lnk.bc4_otf), .cke(lnk.cke), .dll_locked(lnk.dll_locked),
    .rd_window(lnk.rd_window), .wr_recov_start(lnk.wr_recov_start), .int_precharge(lnk.int_precharge));
  // ****
  // Clock, event log and tasks
  // ****
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (lnk.cmd_valid === 1'b1) begin
      if (lnk.cmd === DTR_CMD_REF) begin
        t_refp = t_cmd[5];
        n_ref++;
      end
      t_cmd[lnk.cmd] = cyc;
    end
    if (lnk.wr_recov_start === 1'b1) t_wr = cyc;
    if (lnk.rd_window === 1'b1) t_rd = cyc;
    if (lnk.int_precharge === 1'b1) t_ip = cyc;
  end
  task automatic chk(input int got, input int exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Waits long enough for the slowest answer, a write with auto precharge
  task automatic req(input dtr_cmd_t c, input logic ap, input logic b4);
    int n;
    n = 0;
    req_cmd = c;
    req_ap = ap;
    req_bc4 = b4;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (16) @(negedge mclk);
  endtask
  task automatic wait_ref(input int k);
    int n0;
    n0 = n_ref;
    for (int i = 0; i < 900 && n_ref < n0 + k; i++) @(negedge mclk);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {dll_disable, bc4_fixed, temp_hot, temp_xhot, slow_clk, req_valid, req_ap, req_bc4} = 8'h00;
    req_cmd = DTR_CMD_RD;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    dll_disable = 1'b1;
    req_valid = 1'b1;
    repeat (30) @(negedge mclk);
    chk(t_cmd[2], 0);
    dll_disable = 1'b0;
    req(DTR_CMD_ACT, 1'b0, 1'b0);
    req(DTR_CMD_RD, 1'b1, 1'b0);
    chk(t_rd - t_cmd[2], `DTR_CL_DEF + `DTR_AL_DEF);
    chk_b(t_ip > t_cmd[1] + `DTR_TRAS_CK - 1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      bc4_fixed = (i == 2);
      req(DTR_CMD_WR, i == 0, i == 1);
      chk(t_wr - t_cmd[3], `DTR_WL_DEF + (i == 2 ? `DTR_BC4_TAIL : `DTR_BL8_TAIL));
      if (i == 0) chk(t_ip - t_wr, `DTR_TWR_CK);
    end
    for (int i = 0; i < 3; i++) begin
      {temp_xhot, temp_hot} = 2'(i);
      wait_ref(2);
      chk_b((t_cmd[5] - t_refp) inside {[r_exp[i]:r_exp[i] + 2]}, 1'b1);
    end
    req_cmd = DTR_CMD_SRE;
    req_valid = 1'b1;
    repeat (60) @(negedge mclk);
    req_valid = 1'b0;
    chk(t_cmd[6], 0);
    {temp_xhot, temp_hot} = 2'b00;
    slow_clk = 1'b1;
    wait_ref(1);
    repeat (4) @(negedge mclk);
    chk_b((t_cmd[4] - t_cmd[5]) inside {[1:2]}, 1'b1);
    slow_clk = 1'b0;
    wait_ref(1);
    req(DTR_CMD_PDE, 1'b0, 1'b0);
    chk_b(t_cmd[7] - t_cmd[5] >= `DTR_TXPDLL_CK, 1'b1);
    chk_b(lnk.cke, 1'b0);
    wait_ref(1);
    chk_b(lnk.cke, 1'b1);
    req(DTR_CMD_SRE, 1'b0, 1'b0);
    chk_b(in_sr, 1'b1);
    chk_b(refresh_busy, 1'b0);
    stop_test;
  end
endmodule

// ===== include/dtr_defines.svh
`ifndef DTR_DEFINES_SVH
`define DTR_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define DTR_TCK_PS        40000
`define DTR_TREFI_PS      7812500
`define DTR_TREFI_CK      ((`DTR_TREFI_PS) / (`DTR_TCK_PS))
`define DTR_TREFI_85_CK   ((`DTR_TREFI_PS / 2) / (`DTR_TCK_PS))
`define DTR_TREFI_105_CK  ((`DTR_TREFI_PS / 8) / (`DTR_TCK_PS))
`define DTR_TRAS_PS       35000
`define DTR_TRAS_CK       (((`DTR_TRAS_PS) + (`DTR_TCK_PS) - 1) / (`DTR_TCK_PS))
`define DTR_TWR_PS        15000
`define DTR_TWR_MIN_CK    4
`define DTR_TWR_NS_CK     (((`DTR_TWR_PS) + (`DTR_TCK_PS) - 1) / (`DTR_TCK_PS))
`define DTR_TWR_CK        ((`DTR_TWR_NS_CK > `DTR_TWR_MIN_CK) ? `DTR_TWR_NS_CK : `DTR_TWR_MIN_CK)
`define DTR_TREFPDEN_CK   2
`define DTR_TXPDLL_CK     10
`define DTR_TRFC_CK       1
`define DTR_BL8_TAIL      4
`define DTR_BC4_TAIL      2
`define DTR_CNT_W         16
`define DTR_LAT_W         5
`define DTR_CL_DEF        5'h06
`define DTR_AL_DEF        5'h00
`define DTR_WL_DEF        5'h05

`endif

// ===== include/dtr_if.sv
interface dtr_if;
  import dtr_pkg::*;
  dtr_cmd_t cmd;
  logic     cmd_valid;
  logic     auto_pre;
  logic     bc4_otf;
  logic     cke;
  logic     dll_locked;
  logic     rd_window;
  logic     wr_recov_start;
  logic     int_precharge;

  modport ctl (output cmd, output cmd_valid, output auto_pre, output bc4_otf, output cke,
               input dll_locked, input rd_window, input wr_recov_start, input int_precharge);
  modport dev (input cmd, input cmd_valid, input auto_pre, input bc4_otf, input cke,
               output dll_locked, output rd_window, output wr_recov_start, output int_precharge);
endinterface

// ===== include/dtr_pkg.sv
package dtr_pkg;
  typedef enum logic [2:0] {
    DTR_CMD_NOP,
    DTR_CMD_ACT,
    DTR_CMD_RD,
    DTR_CMD_WR,
    DTR_CMD_PREA,
    DTR_CMD_REF,
    DTR_CMD_SRE,
    DTR_CMD_PDE
  } dtr_cmd_t;

  typedef enum logic [1:0] {
    DTR_TEMP_NORM,
    DTR_TEMP_HOT,
    DTR_TEMP_XHOT
  } dtr_temp_t;
endpackage

// ===== verilog/dtr_ctl.sv
`include "dtr_defines.svh"

module dtr_ctl import dtr_pkg::*; (
  input  wire logic      mclk,
  input  wire logic      rst,
  dtr_if.ctl             lnk,
  input  wire logic      temp_hot,
  input  wire logic      temp_xhot,
  input  wire logic      slow_clk,
  input  wire logic      req_valid,
  input  wire dtr_cmd_t  req_cmd,
  input  wire logic      req_ap,
  input  wire logic      req_bc4,
  output logic           req_ready,
  output logic           refresh_busy
);
  // ****************************************
  // Temperature inputs come from outside the clock domain
  // ****************************************
  logic hot_s1_r;
  logic hot_s2_r;
  logic xhot_s1_r;
  logic xhot_s2_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      hot_s1_r  <= 1'b0;
      hot_s2_r  <= 1'b0;
      xhot_s1_r <= 1'b0;
      xhot_s2_r <= 1'b0;
    end else begin
      hot_s1_r  <= temp_hot;
      hot_s2_r  <= hot_s1_r;
      xhot_s1_r <= temp_xhot;
      xhot_s2_r <= xhot_s1_r;
    end
  end
  wire dtr_temp_t temp = xhot_s2_r ? DTR_TEMP_XHOT : (hot_s2_r ? DTR_TEMP_HOT : DTR_TEMP_NORM);

  // ****************************************
  // Refresh interval counter
  // ****************************************
  // Intervals are maxima, so the integer division rounds down
  wire [`DTR_CNT_W-1:0] reload =
    (temp == DTR_TEMP_XHOT) ? `DTR_CNT_W'(`DTR_TREFI_105_CK) :
    (temp == DTR_TEMP_HOT)  ? `DTR_CNT_W'(`DTR_TREFI_85_CK)  :
                              `DTR_CNT_W'(`DTR_TREFI_CK);
  logic [`DTR_CNT_W-1:0] refi_r;
  logic [3:0]            owed_r;

  typedef enum logic [2:0] { DTR_S_IDLE, DTR_S_REF, DTR_S_GAP, DTR_S_PREA } dtr_state_t;
  dtr_state_t st_r;
  dtr_state_t st_nxt;
  logic [`DTR_CNT_W-1:0] since_ref_r;

  wire refi_expire = (refi_r == '0);
  wire do_ref      = (st_r == DTR_S_REF);
  // Up to eight refreshes may be postponed, keeping nine within 70.3us
  wire owed_dec    = do_ref && (owed_r != 4'h0);

  // Power-down waits tREFPDEN and the DLL exit time after REFRESH
  wire pd_ok = since_ref_r >= `DTR_CNT_W'(`DTR_TXPDLL_CK > `DTR_TREFPDEN_CK ?
                                          `DTR_TXPDLL_CK : `DTR_TREFPDEN_CK);
  wire rd_ok  = lnk.dll_locked;
  wire sre_ok = !xhot_s2_r;
  wire cmd_ok = (req_cmd == DTR_CMD_RD) ? rd_ok :
                (req_cmd == DTR_CMD_SRE) ? (sre_ok && pd_ok) :
                (req_cmd == DTR_CMD_PDE) ? pd_ok : 1'b1;
  wire idle_go = (st_r == DTR_S_IDLE) && (owed_r == 4'h0);
  assign req_ready    = idle_go && cmd_ok;
  assign refresh_busy = !idle_go;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DTR_S_IDLE: if (owed_r != 4'h0) st_nxt = DTR_S_REF;
      DTR_S_REF:  st_nxt = slow_clk ? DTR_S_PREA : DTR_S_GAP;
      DTR_S_PREA: st_nxt = DTR_S_GAP;
      DTR_S_GAP:  st_nxt = DTR_S_IDLE;
      default:    st_nxt = DTR_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      refi_r      <= `DTR_CNT_W'(`DTR_TREFI_CK);
      owed_r      <= 4'h0;
      st_r        <= DTR_S_IDLE;
      since_ref_r <= `DTR_CNT_W'(`DTR_TXPDLL_CK);
    end else begin
      refi_r <= refi_expire ? reload : refi_r - 1'b1;
      // New debt and a payment in the same cycle cancel, leaving owed_r unchanged
      if (refi_expire && !owed_dec && owed_r != 4'h8)
        owed_r <= owed_r + 4'h1;
      else if (owed_dec && !refi_expire)
        owed_r <= owed_r - 4'h1;
      st_r <= st_nxt;
      if (do_ref)
        since_ref_r <= '0;
      else if (!pd_ok)
        since_ref_r <= since_ref_r + 1'b1;
    end
  end

  // ****************************************
  // Command bus drive
  // ****************************************
  logic                  cmd_v_r;
  dtr_cmd_t              cmd_r;
  logic                  ap_r;
  logic                  bc4_r;
  logic                  cke_r;
  wire                   take = req_valid && req_ready;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_v_r <= 1'b0;
      cmd_r   <= DTR_CMD_NOP;
      ap_r    <= 1'b0;
      bc4_r   <= 1'b0;
      cke_r   <= 1'b1;
    end else begin
      cmd_v_r <= take || do_ref || (st_r == DTR_S_PREA);
      cmd_r   <= do_ref ? DTR_CMD_REF : (st_r == DTR_S_PREA) ? DTR_CMD_PREA :
                 take ? req_cmd : DTR_CMD_NOP;
      ap_r    <= take && req_ap;
      bc4_r   <= take && req_bc4;
      if (take && (req_cmd == DTR_CMD_SRE || req_cmd == DTR_CMD_PDE))
        cke_r <= 1'b0;
      else if (owed_r != 4'h0 || (take && req_cmd == DTR_CMD_NOP))
        cke_r <= 1'b1;
    end
  end
  assign lnk.cmd       = cmd_r;
  assign lnk.cmd_valid = cmd_v_r;
  assign lnk.auto_pre  = ap_r;
  assign lnk.bc4_otf   = bc4_r;
  assign lnk.cke       = cke_r;
endmodule

// ===== verilog/dtr_dev.sv
`include "dtr_defines.svh"

module dtr_dev import dtr_pkg::*; (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  dtr_if.dev                         lnk,
  input  wire logic                  dll_disable,
  input  wire logic                  bc4_fixed,
  input  wire logic [`DTR_LAT_W-1:0] cl,
  input  wire logic [`DTR_LAT_W-1:0] al,
  input  wire logic [`DTR_LAT_W-1:0] wl,
  output logic                       in_self_refresh
);
  // ****************************************
  // Command decode
  // ****************************************
  wire is_act = lnk.cmd_valid && (lnk.cmd == DTR_CMD_ACT);
  wire is_rd  = lnk.cmd_valid && (lnk.cmd == DTR_CMD_RD);
  wire is_wr  = lnk.cmd_valid && (lnk.cmd == DTR_CMD_WR);
  wire is_sre = lnk.cmd_valid && (lnk.cmd == DTR_CMD_SRE);

  logic [`DTR_CNT_W-1:0] ras_cnt_r;
  logic [`DTR_CNT_W-1:0] rd_cnt_r;
  logic [`DTR_CNT_W-1:0] wr_cnt_r;
  logic [`DTR_CNT_W-1:0] pre_cnt_r;
  logic                  ap_pend_r;
  logic                  rd_pend_r;
  logic                  wr_pend_r;
  logic                  rd_window_r;
  logic                  wr_start_r;
  logic                  pre_r;
  logic                  sr_r;

  // Read strobe window starts CL+AL-1 after READ in DLL-off mode
  wire [`DTR_CNT_W-1:0] rd_delay =
    `DTR_CNT_W'(cl) + `DTR_CNT_W'(al) - `DTR_CNT_W'(dll_disable);
  // Write recovery starts WL+4 (BL8/OTF BC4) or WL+2 (fixed BC4)
  wire [`DTR_CNT_W-1:0] wr_delay = `DTR_CNT_W'(wl) +
    (bc4_fixed ? `DTR_CNT_W'(`DTR_BC4_TAIL) : `DTR_CNT_W'(`DTR_BL8_TAIL));
  wire ras_met = (ras_cnt_r >= `DTR_CNT_W'(`DTR_TRAS_CK));
  wire fire_pre = ap_pend_r && ras_met && (pre_cnt_r == '0);

  // ****************************************
  // Timers
  // ****************************************
  // Spacing is judged in whole cycles only, so jitter never breaks it
  always_ff @(posedge mclk) begin
    if (rst) begin
      ras_cnt_r   <= '0;
      rd_cnt_r    <= '0;
      wr_cnt_r    <= '0;
      pre_cnt_r   <= '0;
      ap_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      wr_pend_r   <= 1'b0;
      rd_window_r <= 1'b0;
      wr_start_r  <= 1'b0;
      pre_r       <= 1'b0;
      sr_r        <= 1'b0;
    end else begin
      ras_cnt_r   <= is_act ? '0 : (ras_met ? ras_cnt_r : ras_cnt_r + 1'b1);
      rd_window_r <= 1'b0;
      wr_start_r  <= 1'b0;
      pre_r       <= 1'b0;
      // Counters load one less than the delay, as the pulse flop adds a cycle
      if (is_rd && (rd_delay <= `DTR_CNT_W'(1))) begin
        rd_window_r <= 1'b1;
      end else if (is_rd) begin
        rd_pend_r <= 1'b1;
        rd_cnt_r  <= rd_delay - `DTR_CNT_W'(1);
      end else if (rd_pend_r) begin
        if (rd_cnt_r <= `DTR_CNT_W'(1)) begin
          rd_pend_r   <= 1'b0;
          rd_window_r <= 1'b1;
        end
        rd_cnt_r <= rd_cnt_r - 1'b1;
      end
      if (is_wr) begin
        wr_pend_r <= 1'b1;
        wr_cnt_r  <= wr_delay - `DTR_CNT_W'(1);
      end else if (wr_pend_r) begin
        if (wr_cnt_r <= `DTR_CNT_W'(1)) begin
          wr_pend_r  <= 1'b0;
          wr_start_r <= 1'b1;
          if (ap_pend_r)
            pre_cnt_r <= `DTR_CNT_W'(`DTR_TWR_CK - 1);
        end
        wr_cnt_r <= wr_cnt_r - 1'b1;
      end else if (pre_cnt_r != '0) begin
        pre_cnt_r <= pre_cnt_r - 1'b1;
      end
      // Internal precharge held off until tRAS has passed since ACTIVATE
      if ((is_rd || is_wr) && lnk.auto_pre) begin
        ap_pend_r <= 1'b1;
      end else if (fire_pre && !wr_pend_r) begin
        ap_pend_r <= 1'b0;
        pre_r     <= 1'b1;
      end
      if (is_sre)
        sr_r <= 1'b1;
      else if (lnk.cke)
        sr_r <= 1'b0;
    end
  end

  assign lnk.dll_locked     = !dll_disable;
  assign lnk.rd_window      = rd_window_r;
  assign lnk.wr_recov_start = wr_start_r;
  assign lnk.int_precharge  = pre_r;
  assign in_self_refresh    = sr_r;
endmodule
